// ---- scs_clock_selector.v ----
// System clock source selector with APB control registers.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.vh"

// Contract
// R1 - Three-bit select picks system clock, switchable live
// R2 - Fast clock divided by 2 up to 64
// R3 - Slow source bit picks RC or crystal
// R4 - Every select value maps to a real source
// R5 - Fast RC runs at 8, 12 or 16 MHz
// R6 - Software matches fast frequency to configuration
// R7 - Crystal unusable until start-up delay passes
// R8 - Drive mode: 01 quick, 00 low, 1x ESR
// R9 - Crystal works in every drive mode
// R10 - Drive mode locked while crystal drives system
// R11 - Fast oscillator on after switch per enable
// R12 - Pin-share bits connect crystal pins or I/O
// R13 - System clock gated in halt; sub clock optional
// R14 - Oscillators also clock watchdog and time base
// R15 - Fast flag clears then sets; frequency then applies
// R16 - Crystal flag clears on enable, sets when stable
// R17 - Software waits four periods after switching
// R18 - Clock switches without runts or glitches
module scs_clock_selector #(
  parameter integer FAST_SETTLE_CYC = `SCS_FAST_SETTLE_US * `SCS_PCLK_MHZ,
  parameter integer XTAL_QUICK_CYC  = `SCS_XTAL_QUICK_US * `SCS_PCLK_MHZ,
  parameter integer XTAL_SLOW_CYC   = `SCS_XTAL_SLOW_US * `SCS_PCLK_MHZ,
  parameter integer XTAL_ESR_CYC    = `SCS_XTAL_HIGH_ESR_US * `SCS_PCLK_MHZ
) (
  input  wire        pclk,              // Bus and sampling clock.
  input  wire        presetn,           // Asynchronous reset, active low.
  input  wire        psel,              // APB select.
  input  wire        penable,           // APB access phase.
  input  wire        pwrite,            // APB direction, high for write.
  input  wire [7:0]  paddr,             // APB byte address.
  input  wire [31:0] pwdata,            // APB write data.
  output wire [31:0] prdata,            // APB read data.
  output wire        pready,            // APB ready.
  output wire        pslverr,           // APB error on unmapped address.
  input  wire        cpu_halt,          // CPU halted, same clock domain.
  input  wire        fast_osc_clk,      // Fast RC oscillator output.
  input  wire        slow_rc_clk,       // Slow RC oscillator output.
  input  wire        crystal_clk,       // Crystal oscillator output.
  output wire        sys_clk,           // Selected system clock.
  output wire        sub_clk,           // Sub clock for peripherals.
  output wire        wdt_clk,           // Watchdog clock, always running.
  output wire        time_base_clk,     // Time-base clock.
  output wire        fast_osc_run,      // Fast oscillator enable.
  output wire [1:0]  fast_freq_code,    // Applied fast frequency code.
  output wire        crystal_osc_run,   // Crystal oscillator enable.
  output wire [1:0]  crystal_drive_out, // Crystal drive mode to analog.
  output wire        crystal_pin_a_osc, // Pin A connected to crystal.
  output wire        crystal_pin_b_osc  // Pin B connected to crystal.
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Half period of the divided fast clock in fast-source rising edges.
  function [5:0] half_count;
    input [2:0] sel;
    begin
      half_count = 6'h01 << (sel - 3'h1);
    end
  endfunction

  // The spare code 11 runs the fast RC at 8 MHz.
  function [1:0] norm_freq;
    input [1:0] code;
    begin
      norm_freq = (code == `SCS_FREQ_ALIAS_8M) ? `SCS_FREQ_8M : code;
    end
  endfunction

  // Start-up time for a given crystal drive mode.
  function [31:0] xtal_wait;
    input [1:0] mode;
    begin
      if (mode[1])
        xtal_wait = XTAL_ESR_CYC;
      else if (mode == `SCS_MODE_QUICK)
        xtal_wait = XTAL_QUICK_CYC;
      else
        xtal_wait = XTAL_SLOW_CYC;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Reset words, sliced per field so no value is silently truncated.
  localparam [7:0] SCC_RST   = `SCS_SCC_RESET;
  localparam [7:0] FAST_OSC_CONTROL_RST = `SCS_FAST_OSC_CONTROL_RESET;
  localparam [7:0] CRYSTAL_OSC_CONTROL_RST  = `SCS_CRYSTAL_OSC_CONTROL_RESET;
  localparam [7:0] PIN_RST   = `SCS_PIN_RESET;

  reg  [2:0]  sel_ff;           // Requested system clock select.
  reg         fss_ff;           // Requested slow source.
  reg         fhiden_ff;        // Fast oscillator kept in halt.
  reg         fsiden_ff;        // Slow oscillator kept in halt.
  reg  [1:0]  freq_ff;          // Requested fast frequency.
  reg         fast_en_ff;       // Fast oscillator enable bit.
  reg         fast_flag_ff;     // Fast oscillator stable.
  reg  [31:0] fast_cnt_ff;      // Fast settle counter.
  reg  [1:0]  mode_ff;          // Crystal drive mode.
  reg         xtal_en_ff;       // Crystal enable bit.
  reg         xtal_flag_ff;     // Crystal stable.
  reg  [31:0] xtal_cnt_ff;      // Crystal start-up counter.
  reg  [1:0]  pin_ff;           // Pin sharing bits.
  reg  [31:0] prdata_ff;
  reg         pready_ff;
  reg         pslverr_ff;
  reg  [1:0]  fast_sync_ff;     // Two-flop synchroniser.
  reg  [1:0]  rc_sync_ff;
  reg  [1:0]  xtal_sync_ff;
  reg  [2:0]  act_sel_ff;       // Select now driving the output.
  reg         act_fss_ff;
  reg         swap_ff;          // Switch in progress, output held low.
  reg  [5:0]  div_cnt_ff;
  reg         src_hist_ff;      // Selected source level, one cycle old.
  reg         sys_clk_ff;
  reg         sub_clk_ff;
  reg         wdt_clk_ff;
  reg         fast_run_ff;
  reg  [1:0]  fast_code_ff;

  wire        wr_go   = psel & penable & pready_ff & pwrite;
  wire        setup   = psel & ~penable & ~pready_ff;
  wire        hit_scc = (paddr == `SCS_ADDR_SYS_CLK_CTRL);
  wire        hit_hrc = (paddr == `SCS_ADDR_FAST_OSC_CTRL);
  wire        hit_xtc = (paddr == `SCS_ADDR_CRYSTAL_CTRL);
  wire        hit_pin = (paddr == `SCS_ADDR_PIN_SHARE_CTRL);
  wire        mapped  = hit_scc | hit_hrc | hit_xtc | hit_pin;
  wire        xtal_sys = (sel_ff == `SCS_SEL_SUB) & fss_ff;
  wire        fast_lvl = fast_sync_ff[1] & fast_flag_ff;
  wire        xtal_lvl = xtal_sync_ff[1] & xtal_flag_ff;
  wire        rc_lvl   = rc_sync_ff[1];
  wire [1:0]  new_freq = norm_freq(pwdata[`SCS_FAST_OSC_CONTROL_FREQ_HI:
                                          `SCS_FAST_OSC_CONTROL_FREQ_LO]);
  wire        fast_kick = wr_go & hit_hrc & (
                pwdata[`SCS_FAST_OSC_CONTROL_EN_BIT] & ~fast_en_ff |
                new_freq != norm_freq(freq_ff));
  wire        xtal_kick = wr_go & hit_xtc & pwdata[`SCS_CRYSTAL_OSC_CONTROL_EN_BIT] &
                          ~xtal_en_ff;
  reg  [31:0] rd_word;
  reg         sub_lvl;
  reg         src_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, data and error registered at setup.

  // Read mux; reserved bits read as zero.
  always @* begin
    rd_word = 32'h0000_0000;
    if (hit_scc) begin
      rd_word[`SCS_SCC_SEL_HI:`SCS_SCC_SEL_LO] = sel_ff;
      rd_word[`SCS_SCC_FSS_BIT]    = fss_ff;
      rd_word[`SCS_SCC_FHIDEN_BIT] = fhiden_ff;
      rd_word[`SCS_SCC_FSIDEN_BIT] = fsiden_ff;
    end else if (hit_hrc) begin
      rd_word[`SCS_FAST_OSC_CONTROL_FREQ_HI:`SCS_FAST_OSC_CONTROL_FREQ_LO] = freq_ff;
      rd_word[`SCS_FAST_OSC_CONTROL_FLAG_BIT] = fast_flag_ff;
      rd_word[`SCS_FAST_OSC_CONTROL_EN_BIT]   = fast_en_ff;
    end else if (hit_xtc) begin
      rd_word[`SCS_CRYSTAL_OSC_CONTROL_MODE_HI:`SCS_CRYSTAL_OSC_CONTROL_MODE_LO] = mode_ff;
      rd_word[`SCS_CRYSTAL_OSC_CONTROL_FLAG_BIT] = xtal_flag_ff;
      rd_word[`SCS_CRYSTAL_OSC_CONTROL_EN_BIT]   = xtal_en_ff;
    end else if (hit_pin) begin
      rd_word[`SCS_PIN_A_BIT] = pin_ff[0];
      rd_word[`SCS_PIN_B_BIT] = pin_ff[1];
    end
  end

  // Ready rises the edge after setup, so every access takes two cycles.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup)
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  // Unmapped writes are dropped; the drive mode holds while in use.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff     <= SCC_RST[`SCS_SCC_SEL_HI:`SCS_SCC_SEL_LO];
      fss_ff     <= 1'b0;
      fhiden_ff  <= 1'b0;
      fsiden_ff  <= 1'b0;
      freq_ff    <= FAST_OSC_CONTROL_RST[`SCS_FAST_OSC_CONTROL_FREQ_HI:`SCS_FAST_OSC_CONTROL_FREQ_LO];
      fast_en_ff <= FAST_OSC_CONTROL_RST[`SCS_FAST_OSC_CONTROL_EN_BIT];
      mode_ff    <= CRYSTAL_OSC_CONTROL_RST[`SCS_CRYSTAL_OSC_CONTROL_MODE_HI:`SCS_CRYSTAL_OSC_CONTROL_MODE_LO];
      xtal_en_ff <= 1'b0;
      pin_ff     <= {PIN_RST[`SCS_PIN_B_BIT], PIN_RST[`SCS_PIN_A_BIT]};
    end else if (wr_go) begin
      if (hit_scc) begin
        sel_ff    <= pwdata[`SCS_SCC_SEL_HI:`SCS_SCC_SEL_LO]; // R1 R4
        fss_ff    <= pwdata[`SCS_SCC_FSS_BIT];                // R3
        fhiden_ff <= pwdata[`SCS_SCC_FHIDEN_BIT];
        fsiden_ff <= pwdata[`SCS_SCC_FSIDEN_BIT];
      end
      if (hit_hrc) begin
        freq_ff    <= pwdata[`SCS_FAST_OSC_CONTROL_FREQ_HI:`SCS_FAST_OSC_CONTROL_FREQ_LO];
        fast_en_ff <= pwdata[`SCS_FAST_OSC_CONTROL_EN_BIT];
      end
      if (hit_xtc) begin
        if (!xtal_sys) // R10
          mode_ff <= pwdata[`SCS_CRYSTAL_OSC_CONTROL_MODE_HI:`SCS_CRYSTAL_OSC_CONTROL_MODE_LO]; // R8 R9
        xtal_en_ff <= pwdata[`SCS_CRYSTAL_OSC_CONTROL_EN_BIT];
      end
      if (hit_pin) begin
        pin_ff[0] <= pwdata[`SCS_PIN_A_BIT]; // R12
        pin_ff[1] <= pwdata[`SCS_PIN_B_BIT]; // R12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stability flags and settle counters.

  // Enable or frequency change clears the flag; the code applies on set.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_flag_ff <= 1'b0;
      fast_cnt_ff  <= 32'h0000_0000;
      fast_code_ff <= `SCS_FREQ_8M;
    end else if (fast_kick) begin
      fast_flag_ff <= 1'b0; // R15
      fast_cnt_ff  <= 32'h0000_0000;
    end else if (!fast_en_ff) begin
      fast_flag_ff <= 1'b0;
      fast_cnt_ff  <= 32'h0000_0000;
    end else if (!fast_flag_ff) begin
      if (fast_cnt_ff >= FAST_SETTLE_CYC - 1) begin
        fast_flag_ff <= 1'b1;              // R15
        fast_code_ff <= norm_freq(freq_ff); // R5
      end else begin
        fast_cnt_ff <= fast_cnt_ff + 32'h0000_0001;
      end
    end
  end

  // The crystal start-up wait depends on the drive mode in force.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_flag_ff <= 1'b0;
      xtal_cnt_ff  <= 32'h0000_0000;
    end else if (xtal_kick || !xtal_en_ff) begin
      xtal_flag_ff <= 1'b0; // R16
      xtal_cnt_ff  <= 32'h0000_0000;
    end else if (!xtal_flag_ff) begin
      if (xtal_cnt_ff >= xtal_wait(mode_ff) - 1)
        xtal_flag_ff <= 1'b1; // R7 R16
      else
        xtal_cnt_ff <= xtal_cnt_ff + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator input synchronisers.

  // Oscillator outputs are asynchronous; two flops before any use.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_sync_ff <= 2'h0;
      rc_sync_ff   <= 2'h0;
      xtal_sync_ff <= 2'h0;
    end else begin
      fast_sync_ff <= {fast_sync_ff[0], fast_osc_clk};
      rc_sync_ff   <= {rc_sync_ff[0], slow_rc_clk};
      xtal_sync_ff <= {xtal_sync_ff[0], crystal_clk};
    end
  end

  // An unstable crystal contributes a flat low, never a partial clock.
  always @* begin
    sub_lvl = act_fss_ff ? xtal_lvl : rc_lvl; // R3 R7
    src_lvl = (act_sel_ff == `SCS_SEL_SUB) ? sub_lvl : fast_lvl; // R1 R4
  end

  ////////////////////////////////////////////////////////////////////////////
  // Glitch-free source switch and divider.

  // A new select is taken only while the output is low, and the output
  // then waits for the new source to be low, so no runt phase appears.
  // Division counts sampled edges, so the fast source must stay under
  // half the bus clock rate to be followed faithfully.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_sel_ff  <= SCC_RST[`SCS_SCC_SEL_HI:`SCS_SCC_SEL_LO];
      act_fss_ff  <= 1'b0;
      swap_ff     <= 1'b1;
      div_cnt_ff  <= 6'h00;
      src_hist_ff <= 1'b0;
      sys_clk_ff  <= 1'b0;
    end else begin
      src_hist_ff <= src_lvl;
      if (cpu_halt) begin
        sys_clk_ff <= 1'b0; // R13
      end else if (!sys_clk_ff &&
                   (sel_ff != act_sel_ff || fss_ff != act_fss_ff)) begin
        act_sel_ff <= sel_ff; // R1 R18
        act_fss_ff <= fss_ff; // R3
        swap_ff    <= 1'b1;   // R18
        div_cnt_ff <= 6'h00;
      end else if (swap_ff) begin
        if (!src_lvl)
          swap_ff <= 1'b0; // R18
      end else if (act_sel_ff == `SCS_SEL_SUB ||
                   act_sel_ff == `SCS_SEL_UNDIV) begin
        sys_clk_ff <= src_lvl;
      end else if (src_lvl && !src_hist_ff) begin
        if (div_cnt_ff == half_count(act_sel_ff) - 6'h01) begin
          div_cnt_ff <= 6'h00;
          sys_clk_ff <= ~sys_clk_ff; // R2
        end else begin
          div_cnt_ff <= div_cnt_ff + 6'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral clocks and oscillator enables.

  // The slow RC always runs the watchdog; sub clock stops in halt unless
  // kept; the fast oscillator obeys its own enable outside halt.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_clk_ff  <= 1'b0;
      wdt_clk_ff  <= 1'b0;
      fast_run_ff <= 1'b1;
    end else begin
      sub_clk_ff  <= (fss_ff ? xtal_lvl : rc_lvl) &
                     ~(cpu_halt & ~fsiden_ff); // R13 R14
      wdt_clk_ff  <= rc_lvl; // R14
      fast_run_ff <= fast_en_ff & ~(cpu_halt & ~fhiden_ff); // R11
    end
  end

  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign sys_clk           = sys_clk_ff;
  assign sub_clk           = sub_clk_ff;
  assign wdt_clk           = wdt_clk_ff;
  assign time_base_clk     = sub_clk_ff;
  assign fast_osc_run      = fast_run_ff;
  assign fast_freq_code    = fast_code_ff;
  assign crystal_osc_run   = xtal_en_ff;
  assign crystal_drive_out = mode_ff;
  assign crystal_pin_a_osc = pin_ff[0];
  assign crystal_pin_b_osc = pin_ff[1];

endmodule
`default_nettype wire

// ---- scs_map.vh ----
// Register map, field positions, reset values and timings of the clock selector.
`ifndef SCS_MAP_VH
`define SCS_MAP_VH

// Register byte addresses.
`define SCS_ADDR_SYS_CLK_CTRL    8'h00
`define SCS_ADDR_FAST_OSC_CTRL   8'h04
`define SCS_ADDR_CRYSTAL_CTRL    8'h08
`define SCS_ADDR_PIN_SHARE_CTRL  8'h0C

// System clock control fields.
`define SCS_SCC_SEL_HI           7
`define SCS_SCC_SEL_LO           5
`define SCS_SCC_FSS_BIT          2
`define SCS_SCC_FHIDEN_BIT       1
`define SCS_SCC_FSIDEN_BIT       0
`define SCS_SCC_RESET            8'h00
`define SCS_SEL_SUB              3'h7
`define SCS_SEL_UNDIV            3'h0

// Fast oscillator control fields.
`define SCS_FAST_OSC_CONTROL_FREQ_HI        3
`define SCS_FAST_OSC_CONTROL_FREQ_LO        2
`define SCS_FAST_OSC_CONTROL_FLAG_BIT       1
`define SCS_FAST_OSC_CONTROL_EN_BIT         0
`define SCS_FAST_OSC_CONTROL_RESET          8'h01
`define SCS_FREQ_8M              2'h0
`define SCS_FREQ_ALIAS_8M        2'h3

// Crystal oscillator control fields.
`define SCS_CRYSTAL_OSC_CONTROL_MODE_HI         3
`define SCS_CRYSTAL_OSC_CONTROL_MODE_LO         2
`define SCS_CRYSTAL_OSC_CONTROL_FLAG_BIT        1
`define SCS_CRYSTAL_OSC_CONTROL_EN_BIT          0
`define SCS_CRYSTAL_OSC_CONTROL_RESET           8'h00
`define SCS_MODE_LOW_POWER       2'h0
`define SCS_MODE_QUICK           2'h1

// Pin sharing control fields: 1 connects the pin to the crystal.
`define SCS_PIN_A_BIT            0
`define SCS_PIN_B_BIT            1
`define SCS_PIN_RESET            8'h00

// Settling times in microseconds and the clock rate in MHz.
`define SCS_PCLK_MHZ             25
`define SCS_FAST_SETTLE_US       16
`define SCS_XTAL_QUICK_US        1000
`define SCS_XTAL_SLOW_US         2000
`define SCS_XTAL_HIGH_ESR_US     2000

`endif

// ---- scs_monitor.sv ----
// Port-level assertion checker for the clock selector.
`timescale 1ns/1ps
`default_nettype none
module scs_monitor (
  input wire logic        pclk,              // Clock.
  input wire logic        presetn,           // Reset, active low.
  input wire logic        psel,              // APB select.
  input wire logic        penable,           // APB enable.
  input wire logic        pwrite,            // APB direction.
  input wire logic [7:0]  paddr,             // APB address.
  input wire logic [31:0] pwdata,            // APB write data.
  input wire logic        pready,            // APB ready.
  input wire logic        pslverr,           // APB error.
  input wire logic        cpu_halt,          // CPU halted.
  input wire logic        sys_clk,           // System clock.
  input wire logic        fast_osc_run,      // Fast oscillator enable.
  input wire logic        crystal_osc_run,   // Crystal enable.
  input wire logic [1:0]  crystal_drive_out, // Drive mode.
  input wire logic        crystal_pin_a_osc, // Pin A on crystal.
  input wire logic        crystal_pin_b_osc  // Pin B on crystal.
);
  logic [7:0] scc_ff;
  wire  [1:0] wd_mode = pwdata[3:2];
  wire  [1:0] wd_pins = pwdata[1:0];
  wire        wd_en   = pwdata[0];
  wire        wr_done = psel && penable && pready && pwrite;
  wire        locked  = (scc_ff[7:5] == 3'h7) && scc_ff[2];

  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the clock control word, needed to know when the mode locks.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scc_ff <= 8'h00;
    end else if (wr_done && paddr == 8'h00) begin
      scc_ff <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Bus timing and decode, then the control outputs.
  a_setup_then_access: assert property (s_setup |=> s_access)
    else $error("access cycle missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_unmapped: assert property (s_access |->
    pslverr == (paddr > 8'h0C || paddr[1:0] != 2'h0))
    else $error("pslverr wrong for address");
  a_pin_share: assert property (
    s_access and (pwrite && paddr == 8'h0C) |=>
    {crystal_pin_b_osc, crystal_pin_a_osc} == $past(wd_pins))
    else $error("pin share outputs not written");
  a_xtal_enable: assert property (
    s_access and (pwrite && paddr == 8'h08) |=>
    crystal_osc_run == $past(wd_en))
    else $error("crystal enable not written");
  a_mode_locked: assert property (
    s_access and (pwrite && paddr == 8'h08 && locked) |=>
    $stable(crystal_drive_out))
    else $error("drive mode changed while locked");
  a_mode_written: assert property (
    s_access and (pwrite && paddr == 8'h08 && !locked) |=>
    crystal_drive_out == $past(wd_mode))
    else $error("drive mode not written");
  a_halt_gates: assert property (cpu_halt [*3] |-> !sys_clk)
    else $error("sys_clk runs in halt");
  a_fast_stops: assert property (
    (cpu_halt && !scc_ff[1]) [*3] |-> !fast_osc_run)
    else $error("fast oscillator kept in halt");
endmodule

bind scs_clock_selector scs_monitor u_scs_monitor (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .cpu_halt, .sys_clk, .fast_osc_run, .crystal_osc_run,
  .crystal_drive_out, .crystal_pin_a_osc, .crystal_pin_b_osc
);
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the clock selector.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int FAST = 8;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, cpu_halt, err;
  logic        fast_osc_clk = 1'b0, slow_rc_clk = 1'b0, crystal_clk = 1'b0;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, sys_clk, sub_clk, wdt_clk, time_base_clk;
  wire         fast_osc_run, crystal_osc_run;
  wire         crystal_pin_a_osc, crystal_pin_b_osc;
  wire  [1:0]  fast_freq_code, crystal_drive_out;
  int          n_mismatch, checks_done;
  int          cyc = 0;

  scs_clock_selector #(.FAST_SETTLE_CYC(FAST), .XTAL_QUICK_CYC(8),
    .XTAL_SLOW_CYC(16), .XTAL_ESR_CYC(16)) u_scs_clock_selector (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cpu_halt, .fast_osc_clk, .slow_rc_clk, .crystal_clk,
    .sys_clk, .sub_clk, .wdt_clk, .time_base_clk, .fast_osc_run,
    .fast_freq_code, .crystal_osc_run, .crystal_drive_out,
    .crystal_pin_a_osc, .crystal_pin_b_osc);

  always #20 pclk = ~pclk;

  // Oscillators: fast period 8, slow RC 32, crystal 40 cycles; plus timeout.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) fast_osc_clk <= ~fast_osc_clk;
    if (cyc % 16 == 15) slow_rc_clk <= ~slow_rc_clk;
    if (cyc % 20 == 19) crystal_clk <= ~crystal_clk;
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Holds the whole request until pready is sampled high.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd, e);
  endtask

  // Counts rising edges over 1024 cycles; one edge of phase slack.
  task automatic near(string name, int which, int e);
    int n;
    logic p, c;
    n = 0;
    p = 1'b0;
    repeat (1024) begin
      @(posedge pclk);
      c = which == 0 ? sys_clk : which == 1 ? sub_clk :
          which == 2 ? wdt_clk : time_base_clk;
      if (c === 1'b1 && p === 1'b0) n++;
      p = c;
    end
    chk(name, (n >= e - 1 && n <= e + 1) ? e : n, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("fast_osc_run", fast_osc_run, 1);
    rdc(8'h00, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h0C, 32'h0);
    repeat (FAST + 10) @(posedge pclk);
    rdc(8'h04, 32'h03);
    apb(1'b1, 8'h10, 32'hFF);
    chk("pslverr", err, 1);
    rdc(8'h10, 32'h0);
    chk("pslverr", err, 1);
  endtask

  task automatic t_freq;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 8'h04, 32'(c * 4 + 1));
      repeat (FAST + 10) @(posedge pclk);
      chk("fast_freq_code", fast_freq_code, c == 3 ? 0 : c);
      rdc(8'h04, 32'(c * 4 + 3));
    end
    apb(1'b1, 8'h04, 32'h0);
    repeat (2) @(posedge pclk);
    chk("fast_osc_run", fast_osc_run, 0);
    apb(1'b1, 8'h04, 32'h01);
    rdc(8'h04, 32'h01);
    repeat (FAST + 10) @(posedge pclk);
  endtask

  task automatic t_xtal;
    apb(1'b1, 8'h08, 32'h01);
    rdc(8'h08, 32'h01);
    repeat (30) @(posedge pclk);
    rdc(8'h08, 32'h03);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 8'h08, 32'(m * 4 + 1));
      @(posedge pclk);
      chk("crystal_drive_out", crystal_drive_out, m);
      chk("crystal_osc_run", crystal_osc_run, 1);
    end
    apb(1'b1, 8'h08, 32'h05);
    repeat (30) @(posedge pclk);
  endtask

  task automatic t_sel;
    apb(1'b1, 8'h0C, 32'h03);
    @(posedge pclk);
    chk("pins", {crystal_pin_b_osc, crystal_pin_a_osc}, 2'h3);
    for (int s = 0; s < 7; s++) begin
      apb(1'b1, 8'h00, 32'(s << 5));
      repeat (300) @(posedge pclk);
      near("sys_clk rises", 0, 128 >> s);
    end
    apb(1'b1, 8'h00, 32'hE0);
    repeat (300) @(posedge pclk);
    near("sys_clk rises", 0, 32);
    apb(1'b1, 8'h00, 32'hE4);
    repeat (300) @(posedge pclk);
    near("sys_clk rises", 0, 26);
    apb(1'b1, 8'h08, 32'h01);
    rdc(8'h08, 32'h07);
    apb(1'b1, 8'h00, 32'h04);
    apb(1'b1, 8'h08, 32'h01);
    @(posedge pclk);
    chk("crystal_drive_out", crystal_drive_out, 0);
  endtask

  task automatic t_halt;
    apb(1'b1, 8'h00, 32'h0);
    repeat (20) @(posedge pclk);
    cpu_halt <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("fast_osc_run", fast_osc_run, 0);
    near("sys_clk rises", 0, 0);
    near("sub_clk rises", 1, 0);
    near("wdt_clk rises", 2, 32);
    apb(1'b1, 8'h00, 32'h03);
    repeat (5) @(posedge pclk);
    chk("fast_osc_run", fast_osc_run, 1);
    near("sub_clk rises", 1, 32);
    near("time_base_clk rises", 3, 32);
    cpu_halt <= 1'b0;
  endtask

  task automatic results;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, cpu_halt} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    {n_mismatch, checks_done} = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_freq();
    t_xtal();
    t_sel();
    t_halt();
    results();
  end
endmodule
`default_nettype wire
